// *** hdl/mfp_pin_config.sv ***
/*
 * mfp_pin_config: setup registers and pad control for the single-wire host
 * pin and the charge-off indicator pin.
 * Assumes a synchronous byte register port and synchronous pad inputs.
 */
// The implementer's own choices: the strobed register port and the register offsets.
// Summary of operation
// - host pin function field: 0 link, 1 output, 2 unused, 3 analog
// - link mode option bit 5 inverts output; ignored in general output mode
// - option bit 3 picks 1.8 V rail or ldo rail for high drive
// - option bit 2 turns on weak pull-up to ldo rail
// - option bit 1: high floats when clear, drives when set; ldo forces drive
// - option bit 0 turns on weak pull-down to ground
// - analog mode reads option bits as three two-bit fields
// - analog bits 5-4: 18k pull-up, 180k pull-up, or none
// - analog bits 3-2: 18K, 180K, custom model, or raw counts
// - analog bits 1-0: analog, cell temp, report only, fet temp
// - host pin setup is eight bits, resets to 0x00
// - charge-off pin has its own eight-bit setup, same layout, reset 0x00
// - charge-off pin function: 0 unused, 1 output, 2 indicator, 3 analog
// - indicator option bit 5 clear: pin high while charging is disabled
`default_nettype none

module mfp_pin_config
	import mfp_pkg::*;
(
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              sys_rst,
	// register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	// host link engine and general outputs
	input  wire logic              link_tx_level,
	input  wire logic              link_tx_drive,
	output logic                   link_rx_level,
	input  wire logic              host_gpo_level,
	input  wire logic              charge_gpo_level,
	// charge switch state
	input  wire logic              charge_switch_off,
	// single_wire_host_pin pad
	input  wire logic              host_pad_in,
	output logic                   host_pad_out,
	output logic                   host_pad_oe_n,
	output logic                   host_supply_sel,
	output logic                   host_pull_up,
	output logic                   host_pull_down,
	output logic                   host_analog_en,
	output logic                   host_pu18k,
	output logic                   host_pu180k,
	output logic      [1:0]        host_poly_sel,
	output logic      [1:0]        host_meas_type,
	// charge_off_indicator_pin pad
	output logic                   chg_pad_out,
	output logic                   chg_pad_oe_n,
	output logic                   chg_supply_sel,
	output logic                   chg_pull_up,
	output logic                   chg_pull_down,
	output logic                   chg_analog_en,
	output logic                   chg_pu18k,
	output logic                   chg_pu180k,
	output logic      [1:0]        chg_poly_sel,
	output logic      [1:0]        chg_meas_type
);

	logic [7:0] host_link_pin_setup_q;
	logic [7:0] charge_off_pin_setup_q;
	logic [7:0] reg_rdata_q;
	logic [7:0] rd_mux;
	logic [7:0] status;
	logic       link_rx_q;

	// setup registers; every byte value is legal
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			host_link_pin_setup_q  <= PIN_SETUP_RST;
			charge_off_pin_setup_q <= PIN_SETUP_RST;
		end else if (reg_wr) begin
			if (reg_addr == HOST_LINK_PIN_SETUP_OFS)
				host_link_pin_setup_q <= reg_wdata;
			if (reg_addr == CHARGE_OFF_PIN_SETUP_OFS)
				charge_off_pin_setup_q <= reg_wdata;
		end
	end

	// status: live pad state and the pull-up versus ldo-supply conflict
	always_comb begin
		status = 8'h00;
		status[0] = ~host_pad_oe_n;
		status[1] = ~chg_pad_oe_n;
		// hardware does not block the conflict, it only reports it
		status[2] = host_pull_up && host_supply_sel;
		status[3] = chg_pull_up && chg_supply_sel;
		status[4] = host_pad_in;
		status[5] = chg_pad_out;
	end

	// read decode; unmapped offsets read zero
	always_comb begin
		unique case (reg_addr)
			HOST_LINK_PIN_SETUP_OFS:  rd_mux = host_link_pin_setup_q;
			CHARGE_OFF_PIN_SETUP_OFS: rd_mux = charge_off_pin_setup_q;
			PIN_STATUS_OFS:           rd_mux = status;
			default:                  rd_mux = UNMAPPED_RD;
		endcase
	end

	// read data stand only in the cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			reg_rdata_q <= 8'h00;
		else
			reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
	end

	assign reg_rdata = reg_rdata_q;

	// receive path: undo the link polarity so the engine sees logical data
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			link_rx_q <= 1'b0;
		else
			link_rx_q <= (mfp_role_of(host_link_pin_setup_q, 1'b0) == MFP_ROLE_FUNC)
				&& (host_pad_in ^ host_link_pin_setup_q[OPT_POLARITY]);
	end

	assign link_rx_level = link_rx_q;

	// host pin decode
	mfp_pin_decode #(
		.IS_CHARGE (1'b0)
	) u_host_pin (
		.sys_clk      (sys_clk),
		.sys_rst      (sys_rst),
		.cfg          (host_link_pin_setup_q),
		.fn_level     (link_tx_level),
		.fn_drive     (link_tx_drive),
		.gpo_level    (host_gpo_level),
		.pad_out_q    (host_pad_out),
		.pad_oe_n_q   (host_pad_oe_n),
		.supply_sel_q (host_supply_sel),
		.pull_up_q    (host_pull_up),
		.pull_down_q  (host_pull_down),
		.analog_en_q  (host_analog_en),
		.an_pu18k_q   (host_pu18k),
		.an_pu180k_q  (host_pu180k),
		.poly_sel_q   (host_poly_sel),
		.meas_type_q  (host_meas_type)
	);

	// charge-off pin decode; the indicator always requests drive
	mfp_pin_decode #(
		.IS_CHARGE (1'b1)
	) u_chg_pin (
		.sys_clk      (sys_clk),
		.sys_rst      (sys_rst),
		.cfg          (charge_off_pin_setup_q),
		.fn_level     (charge_switch_off),
		.fn_drive     (1'b1),
		.gpo_level    (charge_gpo_level),
		.pad_out_q    (chg_pad_out),
		.pad_oe_n_q   (chg_pad_oe_n),
		.supply_sel_q (chg_supply_sel),
		.pull_up_q    (chg_pull_up),
		.pull_down_q  (chg_pull_down),
		.analog_en_q  (chg_analog_en),
		.an_pu18k_q   (chg_pu18k),
		.an_pu180k_q  (chg_pu180k),
		.poly_sel_q   (chg_poly_sel),
		.meas_type_q  (chg_meas_type)
	);

	// ---- assertions ----
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	// a setup write followed by the decoder edge
	sequence s_host_write;
		reg_wr && (reg_addr == HOST_LINK_PIN_SETUP_OFS);
	endsequence

	sequence s_host_settled;
		##2 1'b1;
	endsequence

	a_fxn_analog_host: assert property (
		(host_link_pin_setup_q[FXN_MSB:FXN_LSB] == FXN_ANALOG) |=> host_analog_en && host_pad_oe_n)
		else $error("host analog function not reflected");

	a_link_polarity: assert property (
		(host_link_pin_setup_q[FXN_MSB:FXN_LSB] == FXN_HOST_LINK) && link_tx_drive
		&& (link_tx_level == host_link_pin_setup_q[OPT_POLARITY]) |=> !host_pad_oe_n && !host_pad_out)
		else $error("link polarity wrong");

	a_gpo_no_polarity: assert property (
		(host_link_pin_setup_q[FXN_MSB:FXN_LSB] == FXN_GPO) && !host_gpo_level
		|=> !host_pad_oe_n && !host_pad_out)
		else $error("gpo low level not driven low");

	a_supply_select: assert property (
		(host_link_pin_setup_q[FXN_MSB:FXN_LSB] == FXN_GPO)
		|=> host_supply_sel == $past(host_link_pin_setup_q[OPT_SUPPLY]))
		else $error("supply select mismatch");

	a_pull_controls: assert property (
		(charge_off_pin_setup_q[FXN_MSB:FXN_LSB] == FXN_GPO)
		|=> (chg_pull_up == $past(charge_off_pin_setup_q[OPT_PULLUP]))
			&& (chg_pull_down == $past(charge_off_pin_setup_q[OPT_PULLDOWN])))
		else $error("pull controls mismatch");

	a_high_tristate: assert property (
		(host_link_pin_setup_q[FXN_MSB:FXN_LSB] == FXN_GPO) && host_gpo_level
		&& !host_link_pin_setup_q[OPT_DRIVE_HI] && !host_link_pin_setup_q[OPT_SUPPLY]
		|=> host_pad_oe_n)
		else $error("high did not float");

	a_high_ldo_drives: assert property (
		(host_link_pin_setup_q[FXN_MSB:FXN_LSB] == FXN_GPO) && host_gpo_level
		&& host_link_pin_setup_q[OPT_SUPPLY] |=> !host_pad_oe_n && host_pad_out)
		else $error("ldo supply high not driven");

	a_pulldown_off: assert property (
		(host_link_pin_setup_q[FXN_MSB:FXN_LSB] == FXN_ANALOG) |=> !host_pull_down && !host_pull_up)
		else $error("digital pulls active in analog mode");

	a_analog_pullup: assert property (
		(host_link_pin_setup_q == 8'h83) |=> !host_pu18k && !host_pu180k && host_analog_en)
		else $error("no pull-up code mishandled");

	a_analog_fields: assert property (
		(host_link_pin_setup_q[FXN_MSB:FXN_LSB] == FXN_ANALOG)
		|=> (host_poly_sel == $past(host_link_pin_setup_q[AN_POLY_MSB:AN_POLY_LSB]))
			&& (host_meas_type == $past(host_link_pin_setup_q[AN_MEAS_MSB:AN_MEAS_LSB])))
		else $error("analog fields mismatch");

	// reset is the antecedent here, so the default disable must not apply
	a_reset_value: assert property (@(posedge sys_clk) disable iff (1'b0)
		sys_rst |=> (host_link_pin_setup_q == PIN_SETUP_RST)
			&& (charge_off_pin_setup_q == PIN_SETUP_RST))
		else $error("setup reset value wrong");

	a_indicator_pol: assert property (
		(charge_off_pin_setup_q[FXN_MSB:FXN_LSB] == FXN_CHARGE_OFF) && charge_switch_off
		&& !charge_off_pin_setup_q[OPT_POLARITY] && charge_off_pin_setup_q[OPT_DRIVE_HI]
		|=> !chg_pad_oe_n && chg_pad_out)
		else $error("indicator not high while charging disabled");

	a_write_to_pad: assert property (
		(s_host_write and (reg_wdata[FXN_MSB:FXN_LSB] == FXN_ANALOG)) ##0 s_host_settled
		|-> host_analog_en)
		else $error("pad controls not updated two edges after write");

	// register port read-back and idle read data
	a_host_readback: assert property (
		reg_rd && (reg_addr == HOST_LINK_PIN_SETUP_OFS)
		|=> reg_rdata == $past(host_link_pin_setup_q))
		else $error("host setup read-back wrong");

	a_chg_readback: assert property (
		reg_rd && (reg_addr == CHARGE_OFF_PIN_SETUP_OFS)
		|=> reg_rdata == $past(charge_off_pin_setup_q))
		else $error("charge setup read-back wrong");

	a_rdata_idle: assert property (
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data stood beyond one cycle");

	// code 2 is unused on the host pin
	a_host_unused: assert property (
		(host_link_pin_setup_q[FXN_MSB:FXN_LSB] == FXN_CHARGE_OFF)
		|=> host_pad_oe_n && !host_supply_sel && !host_pull_up && !host_pull_down
			&& !host_analog_en)
		else $error("unused host pin not released");

	// code 0 is unused on the charge-off pin
	a_chg_unused: assert property (
		(charge_off_pin_setup_q[FXN_MSB:FXN_LSB] == FXN_HOST_LINK)
		|=> chg_pad_oe_n && !chg_supply_sel && !chg_pull_up && !chg_pull_down
			&& !chg_analog_en)
		else $error("unused charge pin not released");

	a_rx_outside_link: assert property (
		(host_link_pin_setup_q[FXN_MSB:FXN_LSB] != FXN_HOST_LINK) |=> !link_rx_level)
		else $error("link receive active outside link mode");

	a_analog_18k: assert property (
		(host_link_pin_setup_q[FXN_MSB:FXN_LSB] == FXN_ANALOG)
		&& (host_link_pin_setup_q[AN_PU_MSB:AN_PU_LSB] == AN_PU_18K)
		|=> host_pu18k && !host_pu180k)
		else $error("18k pull-up code mishandled");

	a_chg_analog: assert property (
		(charge_off_pin_setup_q[FXN_MSB:FXN_LSB] == FXN_ANALOG)
		|=> chg_analog_en && chg_pad_oe_n
			&& (chg_meas_type == $past(charge_off_pin_setup_q[AN_MEAS_MSB:AN_MEAS_LSB])))
		else $error("charge analog fields mismatch");

	a_indicator_low: assert property (
		(charge_off_pin_setup_q[FXN_MSB:FXN_LSB] == FXN_CHARGE_OFF) && charge_switch_off
		&& charge_off_pin_setup_q[OPT_POLARITY] |=> !chg_pad_oe_n && !chg_pad_out)
		else $error("indicator not low while charging disabled");

	a_drive_high: assert property (
		(host_link_pin_setup_q[FXN_MSB:FXN_LSB] == FXN_GPO) && host_gpo_level
		&& host_link_pin_setup_q[OPT_DRIVE_HI] |=> !host_pad_oe_n && host_pad_out)
		else $error("drive-high option not driving");

	a_host_pulls: assert property (
		(host_link_pin_setup_q[FXN_MSB:FXN_LSB] == FXN_HOST_LINK)
		|=> (host_pull_down == $past(host_link_pin_setup_q[OPT_PULLDOWN]))
			&& (host_pull_up == $past(host_link_pin_setup_q[OPT_PULLUP])))
		else $error("host pull controls mismatch in link mode");

endmodule : mfp_pin_config

`default_nettype wire

// *** hdl/mfp_pin_decode.sv ***
/*
 * mfp_pin_decode: turns one pin's setup byte plus the live function
 * level into registered pad controls.
 * Assumes the setup byte and levels are synchronous to sys_clk.
 */
`default_nettype none

module mfp_pin_decode
	import mfp_pkg::*;
#(
	parameter bit IS_CHARGE = 1'b0
) (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       sys_rst,
	// configuration and requests
	input  wire logic [7:0] cfg,
	input  wire logic       fn_level,
	input  wire logic       fn_drive,
	input  wire logic       gpo_level,
	// pad controls
	output logic            pad_out_q,
	output logic            pad_oe_n_q,
	output logic            supply_sel_q,
	output logic            pull_up_q,
	output logic            pull_down_q,
	// analog controls
	output logic            analog_en_q,
	output logic            an_pu18k_q,
	output logic            an_pu180k_q,
	output logic [1:0]      poly_sel_q,
	output logic [1:0]      meas_type_q
);

	mfp_role_t role;
	logic      out_cap;
	logic      level;
	logic      drive;
	logic      pad_out_d;
	logic      pad_oe_n_d;

	// role and requested logic level
	always_comb begin
		role    = mfp_role_of(cfg, IS_CHARGE);
		out_cap = (role == MFP_ROLE_FUNC) || (role == MFP_ROLE_GPO);
		// polarity only applies to the dedicated function, never to gpo
		level   = (role == MFP_ROLE_FUNC) ? (fn_level ^ cfg[OPT_POLARITY]) : gpo_level;
		drive   = (role == MFP_ROLE_GPO) || ((role == MFP_ROLE_FUNC) && fn_drive);
	end

	// high either drives or floats; floating is impossible on the ldo supply
	always_comb begin
		pad_out_d  = 1'b0;
		pad_oe_n_d = 1'b1;
		if (drive) begin
			if (!level) begin
				pad_oe_n_d = 1'b0;
			end else if (cfg[OPT_DRIVE_HI] || cfg[OPT_SUPPLY]) begin
				pad_out_d  = 1'b1;
				pad_oe_n_d = 1'b0;
			end
		end
	end

	// registered pad drive
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pad_out_q  <= 1'b0;
			pad_oe_n_q <= 1'b1;
		end else begin
			pad_out_q  <= pad_out_d;
			pad_oe_n_q <= pad_oe_n_d;
		end
	end

	// registered digital pad options
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			supply_sel_q <= 1'b0;
			pull_up_q    <= 1'b0;
			pull_down_q  <= 1'b0;
		end else begin
			supply_sel_q <= out_cap && cfg[OPT_SUPPLY];
			pull_up_q    <= out_cap && cfg[OPT_PULLUP];
			pull_down_q  <= out_cap && cfg[OPT_PULLDOWN];
		end
	end

	// registered analog options; zeroed outside analog role
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			analog_en_q <= 1'b0;
			an_pu18k_q  <= 1'b0;
			an_pu180k_q <= 1'b0;
			poly_sel_q  <= 2'h0;
			meas_type_q <= 2'h0;
		end else begin
			analog_en_q <= (role == MFP_ROLE_ANALOG);
			an_pu18k_q  <= (role == MFP_ROLE_ANALOG) && (cfg[AN_PU_MSB:AN_PU_LSB] == AN_PU_18K);
			an_pu180k_q <= (role == MFP_ROLE_ANALOG) && (cfg[AN_PU_MSB:AN_PU_LSB] == AN_PU_180K);
			poly_sel_q  <= (role == MFP_ROLE_ANALOG) ? cfg[AN_POLY_MSB:AN_POLY_LSB] : 2'h0;
			meas_type_q <= (role == MFP_ROLE_ANALOG) ? cfg[AN_MEAS_MSB:AN_MEAS_LSB] : 2'h0;
		end
	end

endmodule : mfp_pin_decode

`default_nettype wire

// *** hdl/mfp_pkg.sv ***
/*
 * mfp_pkg: register map, field positions, function codes and the
 * function-select decode shared by the pin configuration block.
 * Assumes a single 40 MHz core clock and a byte-wide register port.
 */
`default_nettype none

package mfp_pkg;

	// register port geometry
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 8;

	// register offsets
	localparam logic [3:0] HOST_LINK_PIN_SETUP_OFS  = 4'h0;
	localparam logic [3:0] CHARGE_OFF_PIN_SETUP_OFS = 4'h1;
	localparam logic [3:0] PIN_STATUS_OFS           = 4'h2;

	// reset values
	localparam logic [7:0] PIN_SETUP_RST = 8'h00;
	localparam logic [7:0] UNMAPPED_RD   = 8'h00;

	// pin_function_select field
	localparam int unsigned FXN_LSB = 0;
	localparam int unsigned FXN_MSB = 1;

	// pin_option_bits in digital roles (opt n sits at bit n+2)
	localparam int unsigned OPT_POLARITY = 7;
	localparam int unsigned OPT_SUPPLY   = 5;
	localparam int unsigned OPT_PULLUP   = 4;
	localparam int unsigned OPT_DRIVE_HI = 3;
	localparam int unsigned OPT_PULLDOWN = 2;

	// pin_option_bits in analog_input_mode
	localparam int unsigned AN_PU_MSB   = 7;
	localparam int unsigned AN_PU_LSB   = 6;
	localparam int unsigned AN_POLY_MSB = 5;
	localparam int unsigned AN_POLY_LSB = 4;
	localparam int unsigned AN_MEAS_MSB = 3;
	localparam int unsigned AN_MEAS_LSB = 2;

	// function codes (host pin: 0 = link, charge pin: 2 = indicator)
	localparam logic [1:0] FXN_HOST_LINK  = 2'h0;
	localparam logic [1:0] FXN_GPO        = 2'h1;
	localparam logic [1:0] FXN_CHARGE_OFF = 2'h2;
	localparam logic [1:0] FXN_ANALOG     = 2'h3;

	// analog pull-up codes
	localparam logic [1:0] AN_PU_18K  = 2'h0;
	localparam logic [1:0] AN_PU_180K = 2'h1;

	typedef enum logic [1:0] {
		MFP_ROLE_OFF,
		MFP_ROLE_FUNC,
		MFP_ROLE_GPO,
		MFP_ROLE_ANALOG
	} mfp_role_t;

	// pin role from a setup byte; is_charge picks the pin's own table
	function automatic mfp_role_t mfp_role_of(input logic [7:0] cfg, input logic is_charge);
		logic [1:0] fxn;
		fxn = cfg[FXN_MSB:FXN_LSB];
		if (fxn == FXN_ANALOG)
			mfp_role_of = MFP_ROLE_ANALOG;
		else if (fxn == FXN_GPO)
			mfp_role_of = MFP_ROLE_GPO;
		else if (fxn == (is_charge ? FXN_CHARGE_OFF : FXN_HOST_LINK))
			mfp_role_of = MFP_ROLE_FUNC;
		else
			mfp_role_of = MFP_ROLE_OFF;
	endfunction : mfp_role_of

endpackage : mfp_pkg

`default_nettype wire

// *** test/mfp_far_side.sv ***
/*
 * mfp_far_side: the host on the single-wire link, seen from the pad.
 * Assumes an external pull-up on the wire; the host only pulls low.
 */
`default_nettype none

module mfp_far_side (
	// pad of the single-wire host pin
	input  wire logic host_pad_out,
	input  wire logic host_pad_oe_n,
	// host request to pull the wire low
	input  wire logic host_low,
	// wire level read back by the pad
	output logic      host_pad_in
);
	timeunit 1ns;
	timeprecision 100ps;

	// released wire floats up through the pull-up unless the host sinks it
	assign host_pad_in = host_pad_oe_n ? !host_low : host_pad_out;
endmodule : mfp_far_side

`default_nettype wire

// *** test/test_mfp_pin_config.sv ***
/*
 * test_mfp_pin_config: self-checking bench for the pin setup block.
 * Assumes the far-side model in mfp_far_side and a 40 MHz sys_clk.
 */
`default_nettype none

module test_mfp_pin_config;
	import mfp_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	logic       sys_clk, sys_rst, reg_wr, reg_rd, host_low;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic       link_tx_level, link_tx_drive, link_rx_level, host_gpo_level;
	logic       charge_gpo_level, charge_switch_off, host_pad_in;
	logic       host_pad_out, host_pad_oe_n, host_supply_sel, host_pull_up, host_pull_down;
	logic       host_analog_en, host_pu18k, host_pu180k, chg_pad_out, chg_pad_oe_n;
	logic       chg_supply_sel, chg_pull_up, chg_pull_down, chg_analog_en, chg_pu18k;
	logic       chg_pu180k;
	logic [1:0] host_poly_sel, host_meas_type, chg_poly_sel, chg_meas_type;
	int         failures, checked;

	// pad controls of each pin gathered for one compare
	wire [11:0] host_obs = {host_pad_oe_n, host_pad_out, host_supply_sel, host_pull_up,
		host_pull_down, host_analog_en, host_pu18k, host_pu180k, host_poly_sel, host_meas_type};
	wire [11:0] chg_obs = {chg_pad_oe_n, chg_pad_out, chg_supply_sel, chg_pull_up,
		chg_pull_down, chg_analog_en, chg_pu18k, chg_pu180k, chg_poly_sel, chg_meas_type};

	mfp_pin_config u_mfp_pin_config (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .link_tx_level(link_tx_level), .link_tx_drive(link_tx_drive),
		.link_rx_level(link_rx_level), .host_gpo_level(host_gpo_level),
		.charge_gpo_level(charge_gpo_level), .charge_switch_off(charge_switch_off),
		.host_pad_in(host_pad_in), .host_pad_out(host_pad_out), .host_pad_oe_n(host_pad_oe_n),
		.host_supply_sel(host_supply_sel), .host_pull_up(host_pull_up),
		.host_pull_down(host_pull_down), .host_analog_en(host_analog_en),
		.host_pu18k(host_pu18k), .host_pu180k(host_pu180k), .host_poly_sel(host_poly_sel),
		.host_meas_type(host_meas_type), .chg_pad_out(chg_pad_out), .chg_pad_oe_n(chg_pad_oe_n),
		.chg_supply_sel(chg_supply_sel), .chg_pull_up(chg_pull_up),
		.chg_pull_down(chg_pull_down), .chg_analog_en(chg_analog_en), .chg_pu18k(chg_pu18k),
		.chg_pu180k(chg_pu180k), .chg_poly_sel(chg_poly_sel), .chg_meas_type(chg_meas_type));

	mfp_far_side u_mfp_far_side (.host_pad_out(host_pad_out), .host_pad_oe_n(host_pad_oe_n),
		.host_low(host_low), .host_pad_in(host_pad_in));

	// free-running core clock
	always #12.5 sys_clk = ~sys_clk;

	task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// data stand only in the cycle after the read edge
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd

	// expected pad controls worked out from the setup byte and the levels
	function automatic logic [11:0] expect_pad(input logic [7:0] c, input logic charge_switch_drive,
		input logic [3:0] v);
		logic [11:0] e;
		logic        lev;
		e = 12'h800;
		if (c[1:0] == 2'h3) begin
			e = {4'h8, c[2], 1'b1, c[7:6] == 2'h0, c[7:6] == 2'h1, c[5:2]};
			e[7] = 1'b0;
		end else if (c[1:0] == 2'h1 || c[1:0] == (charge_switch_drive ? 2'h2 : 2'h0)) begin
			lev = (c[1:0] == 2'h1) ? v[2] : v[0] ^ c[7];
			e[11] = (!charge_switch_drive && c[1:0] == 2'h0 && !v[1]) || (lev && !c[3] && !c[5]);
			e[10] = lev;
			e[9] = c[5];
			e[8] = c[4];
			e[7] = c[2];
		end
		return e;
	endfunction : expect_pad

	// output value is only judged while the pad is driven
	task automatic pad_cmp(input logic [11:0] obs, input logic [7:0] c, input logic charge_switch_drive,
		input logic [3:0] v);
		logic [11:0] e;
		logic [11:0] o;
		e = expect_pad(c, charge_switch_drive, v);
		o = obs;
		if (e[11]) begin
			o[10] = e[10];
		end
		check(charge_switch_drive ? "chg pad" : "host pad", o, e);
	endtask : pad_cmp

	task automatic t_reset();
		logic [7:0] d;
		check("host pad at reset", host_obs, 12'h800);
		check("chg pad at reset", chg_obs, 12'h800);
		wr(4'h0, 8'hA5);
		wr(4'h1, 8'h5A);
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(4'h0, d);
		check("host setup", d, 8'h00);
		rd(4'h1, d);
		check("chg setup", d, 8'h00);
		wr(4'h0, 8'h03);
		#1;
		check("analog early", host_analog_en, 1'b0);
		@(posedge sys_clk);
		#1;
		check("analog late", host_analog_en, 1'b1);
		$display("test reset done");
	endtask : t_reset

	task automatic t_regs();
		logic [7:0] d;
		wr(4'h0, 8'h31);
		wr(4'h1, 8'h00);
		wr(4'h2, 8'hFF);
		wr(4'hF, 8'hFF);
		rd(4'h0, d);
		check("host setup kept", d, 8'h31);
		rd(4'h1, d);
		check("chg setup kept", d, 8'h00);
		rd(4'hF, d);
		check("unmapped read", d, 8'h00);
		// pull-up with ldo supply is the software slip that gets flagged;
		// host pin drives its low gpo level, charge pin is released
		rd(4'h2, d);
		check("status byte", d, 8'h05);
		$display("test registers done");
	endtask : t_regs

	// every function code with a spread of option bytes and input levels
	task automatic t_pads();
		logic [7:0] opts [10] = '{8'h00, 8'h80, 8'h08, 8'h20, 8'h14, 8'hFC, 8'h40, 8'h54,
			8'h98, 8'hEC};
		logic [7:0] c, d;
		logic [11:0] e;
		for (int i = 0; i < 10; i++) begin
			for (int f = 0; f < 4; f++) begin
				c = opts[i] | 8'(f);
				wr(4'h0, c);
				wr(4'h1, c);
				rd(4'h0, d);
				check("host setup", d, c);
				rd(4'h1, d);
				check("chg setup", d, c);
				for (int v = 0; v < 16; v++) begin
					@(posedge sys_clk);
					link_tx_level <= v[0];
					charge_switch_off <= v[0];
					link_tx_drive <= v[1];
					host_gpo_level <= v[2];
					charge_gpo_level <= v[2];
					host_low <= v[3];
					repeat (2) @(posedge sys_clk);
					#1;
					pad_cmp(host_obs, c, 1'b0, 4'(v));
					pad_cmp(chg_obs, c, 1'b1, 4'(v));
					e = expect_pad(c, 1'b0, 4'(v));
					check("link rx", link_rx_level, (c[1:0] == 2'h0) ?
						((e[11] ? !v[3] : e[10]) ^ c[7]) : 1'b0);
				end
			end
		end
		$display("test pads done");
	endtask : t_pads

	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude

	// inputs settled at time zero, reset held for two cycles
	initial begin
		{sys_clk, reg_wr, reg_rd, host_low, link_tx_level, link_tx_drive} = '0;
		{host_gpo_level, charge_gpo_level, charge_switch_off, reg_addr, reg_wdata} = '0;
		sys_rst = 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		t_reset();
		t_regs();
		t_pads();
		conclude();
	end

	// the full run needs under 3000 cycles
	initial begin
		repeat (10000) @(posedge sys_clk);
		failures++;
		conclude();
	end
endmodule : test_mfp_pin_config

`default_nettype wire
